/* File: common/acd_pkg.sv */
// constants, register map and edge decode for the comparator and reference control
`default_nettype none
package acd_pkg;
  // register bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INPUT_SEL = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_REF_CTRL = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_PIN_EN = 8'h03;
  // status and control field positions
  localparam int unsigned CS_ENABLE_BIT = 7;
  localparam int unsigned CS_HYST_BIT = 6;
  localparam int unsigned CS_FLAG_BIT = 5;
  localparam int unsigned CS_IRQ_EN_BIT = 4;
  localparam int unsigned CS_RESULT_BIT = 3;
  localparam int unsigned CS_PIN_OUT_BIT = 2;
  localparam int unsigned CS_MODE_LSB = 0;
  localparam int unsigned MODE_W = 2;
  // input select field positions
  localparam int unsigned SEL_POS_LSB = 4;
  localparam int unsigned SEL_NEG_LSB = 0;
  localparam int unsigned SEL_W = 2;
  // reference control field positions
  localparam int unsigned REF_EN_BIT = 7;
  localparam int unsigned REF_SRC_BIT = 6;
  localparam int unsigned REF_CODE_LSB = 0;
  localparam int unsigned REF_LEVELS = 64;
  localparam int unsigned REF_CODE_W = $clog2(REF_LEVELS);
  // pin enable field
  localparam int unsigned PIN_EN_LSB = 0;
  localparam int unsigned PIN_EN_W = 3;
  // reset values
  localparam logic [DATA_W-1:0] RST_STATUS_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_INPUT_SEL = 8'h00;
  localparam logic [DATA_W-1:0] RST_REF_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_PIN_EN = 8'h00;
  // edge sensitivity codes
  localparam logic [MODE_W-1:0] MODE_FALL = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RISE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_FALL_ALT = 2'h2;
  localparam logic [MODE_W-1:0] MODE_BOTH = 2'h3;
  // comparator input select codes
  localparam logic [SEL_W-1:0] SEL_EXT0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_EXT1 = 2'h1;
  localparam logic [SEL_W-1:0] SEL_RSVD = 2'h2;
  localparam logic [SEL_W-1:0] SEL_REF = 2'h3;
  // reference full-scale source codes
  localparam logic REF_SRC_BANDGAP = 1'b0;
  localparam logic REF_SRC_SUPPLY = 1'b1;
  // clocks from the first sample of the raw output to a set flag
  localparam int unsigned FLAG_LAG_CLK = 2;

  // true when the transition old_v -> new_v is accepted by the mode
  function automatic logic acd_edge_ok(input logic [MODE_W-1:0] mode, input logic old_v,
                                       input logic new_v);
    case (mode)
      MODE_RISE: return !old_v && new_v;
      MODE_BOTH: return old_v != new_v;
      default: return old_v && !new_v; // fall and its alias
    endcase
  endfunction : acd_edge_ok
endpackage : acd_pkg
`default_nettype wire

/* File: common/acd_edge_if.sv */
// signals between the control core and the edge detector
`timescale 1ns/100ps
`default_nettype none
interface acd_edge_if;
  logic cmp_enable;
  logic stop_mode;
  logic irq_en;
  logic [acd_pkg::MODE_W-1:0] mode;
  logic raw;
  logic result;
  logic result_prev;
  logic edge_hit;
  logic wake;
  modport ctrl (output cmp_enable, stop_mode, irq_en, mode, raw, result, result_prev,
                input edge_hit, wake);
  modport det (input cmp_enable, stop_mode, irq_en, mode, raw, result, result_prev,
               output edge_hit, wake);
endinterface : acd_edge_if
`default_nettype wire

/* File: verilog/acd_edge_detect.sv */
// edge qualification: clocked path and clockless stop-mode wake path
`timescale 1ns/100ps
`default_nettype none
module acd_edge_detect (
  acd_edge_if.det eif
);
  import acd_pkg::*;

  // clocked path compares the two synchronised samples, only while the clock runs
  always_comb begin
    eif.edge_hit = eif.cmp_enable && !eif.stop_mode &&
                   acd_edge_ok(eif.mode, eif.result_prev, eif.result);
  end

  // stop path: raw output against the frozen sample, needs no clock edge
  always_comb begin
    eif.wake = eif.stop_mode && eif.cmp_enable && eif.irq_en &&
               acd_edge_ok(eif.mode, eif.result, eif.raw);
  end
endmodule : acd_edge_detect
`default_nettype wire

/* File: verilog/acd_comparator_dac_control.sv */
// register file, synchroniser, event flag and pin control of the comparator and reference
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module acd_comparator_dac_control (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [acd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [acd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [acd_pkg::DATA_W-1:0] rdata_o,
  input wire logic stop_mode_i,
  input wire logic raw_compare_output_i,
  output logic comparator_enable_o,
  output logic hysteresis_select_o,
  output logic [acd_pkg::SEL_W-1:0] positive_input_select_o,
  output logic [acd_pkg::SEL_W-1:0] negative_input_select_o,
  output logic [acd_pkg::PIN_EN_W-1:0] external_input_pin_enables_o,
  output logic reference_generator_enable_o,
  output logic reference_source_select_o,
  output logic [acd_pkg::REF_CODE_W-1:0] reference_level_code_o,
  output logic result_pin_o,
  output logic result_pin_oe_o,
  output logic irq_o,
  output logic wake_o
);
  import acd_pkg::*;

  // control state
  logic comparator_enable_bit;
  logic hyst_sel;
  logic edge_event_flag;
  logic edge_irq_enable;
  logic result_pin_enable;
  logic [MODE_W-1:0] edge_sensitivity_select;
  logic [SEL_W-1:0] positive_input_select;
  logic [SEL_W-1:0] negative_input_select;
  logic reference_generator_enable;
  logic reference_source_select;
  logic [REF_CODE_W-1:0] reference_level_code;
  logic [PIN_EN_W-1:0] external_input_pin_enables;
  // synchroniser stages and edge history
  logic sync_meta;
  logic synced_compare_result;
  logic result_prev;
  // flag next value and decodes
  logic next_flag;
  logic wr_status;
  logic wr_sel;
  logic wr_ref;
  logic wr_pin;
  logic flag_clear;
  logic irq_q;

  acd_edge_if u_eif ();

  // write decodes
  assign wr_status = wr_i && (addr_i == OFS_STATUS_CTRL);
  assign wr_sel = wr_i && (addr_i == OFS_INPUT_SEL);
  assign wr_ref = wr_i && (addr_i == OFS_REF_CTRL);
  assign wr_pin = wr_i && (addr_i == OFS_PIN_EN);
  assign flag_clear = wr_status && !wdata_i[CS_FLAG_BIT];

  // status and control register, flag excluded
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      comparator_enable_bit <= RST_STATUS_CTRL[CS_ENABLE_BIT];
      hyst_sel <= RST_STATUS_CTRL[CS_HYST_BIT];
      edge_irq_enable <= RST_STATUS_CTRL[CS_IRQ_EN_BIT];
      result_pin_enable <= RST_STATUS_CTRL[CS_PIN_OUT_BIT];
      edge_sensitivity_select <= RST_STATUS_CTRL[CS_MODE_LSB +: MODE_W];
    end else if (wr_status) begin
      comparator_enable_bit <= wdata_i[CS_ENABLE_BIT];
      hyst_sel <= wdata_i[CS_HYST_BIT];
      edge_irq_enable <= wdata_i[CS_IRQ_EN_BIT];
      result_pin_enable <= wdata_i[CS_PIN_OUT_BIT];
      edge_sensitivity_select <= wdata_i[CS_MODE_LSB +: MODE_W];
    end
  end

  // input select register
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      positive_input_select <= RST_INPUT_SEL[SEL_POS_LSB +: SEL_W];
      negative_input_select <= RST_INPUT_SEL[SEL_NEG_LSB +: SEL_W];
    end else if (wr_sel) begin
      positive_input_select <= wdata_i[SEL_POS_LSB +: SEL_W];
      negative_input_select <= wdata_i[SEL_NEG_LSB +: SEL_W];
    end
  end

  // reference generator register, independent of the comparator enable
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reference_generator_enable <= RST_REF_CTRL[REF_EN_BIT];
      reference_source_select <= RST_REF_CTRL[REF_SRC_BIT];
      reference_level_code <= RST_REF_CTRL[REF_CODE_LSB +: REF_CODE_W];
    end else if (wr_ref) begin
      reference_generator_enable <= wdata_i[REF_EN_BIT];
      reference_source_select <= wdata_i[REF_SRC_BIT];
      reference_level_code <= wdata_i[REF_CODE_LSB +: REF_CODE_W];
    end
  end

  // external pin enables
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      external_input_pin_enables <= RST_PIN_EN[PIN_EN_LSB +: PIN_EN_W];
    end else if (wr_pin) begin
      external_input_pin_enables <= wdata_i[PIN_EN_LSB +: PIN_EN_W];
    end
  end

  // two-stage synchroniser plus history; holds while stopped, zero while disabled
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !comparator_enable_bit) begin
      sync_meta <= 1'b0;
      synced_compare_result <= 1'b0;
      result_prev <= 1'b0;
    end else if (!stop_mode_i) begin
      sync_meta <= raw_compare_output_i;
      synced_compare_result <= sync_meta;
      result_prev <= synced_compare_result;
    end
  end

  // connect the edge detector
  assign u_eif.cmp_enable = comparator_enable_bit;
  assign u_eif.stop_mode = stop_mode_i;
  assign u_eif.irq_en = edge_irq_enable;
  assign u_eif.mode = edge_sensitivity_select;
  assign u_eif.raw = raw_compare_output_i;
  assign u_eif.result = synced_compare_result;
  assign u_eif.result_prev = result_prev;

  acd_edge_detect acd_edge_detect_i (
    .eif (u_eif.det)
  );

  // sticky flag: a detected edge wins over a clearing write
  always_comb begin
    next_flag = edge_event_flag;
    if (u_eif.edge_hit) begin
      next_flag = 1'b1;
    end else if (flag_clear) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      edge_event_flag <= RST_STATUS_CTRL[CS_FLAG_BIT];
    end else begin
      edge_event_flag <= next_flag;
    end
  end

  // interrupt request follows the next flag and enable in the same edge
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_q <= 1'b0;
    end else if (wr_status) begin
      irq_q <= next_flag && wdata_i[CS_IRQ_EN_BIT];
    end else begin
      irq_q <= next_flag && edge_irq_enable;
    end
  end

  // read data, present only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !rd_i) begin
      rdata_o <= '0;
    end else begin
      case (addr_i)
        OFS_STATUS_CTRL: begin
          rdata_o <= {comparator_enable_bit, hyst_sel, edge_event_flag, edge_irq_enable,
                      synced_compare_result, result_pin_enable, edge_sensitivity_select};
        end
        OFS_INPUT_SEL: begin
          rdata_o <= {2'h0, positive_input_select, 2'h0, negative_input_select};
        end
        OFS_REF_CTRL: begin
          rdata_o <= {reference_generator_enable, reference_source_select,
                      reference_level_code};
        end
        OFS_PIN_EN: begin
          rdata_o <= {5'h00, external_input_pin_enables};
        end
        default: begin
          rdata_o <= '0;
        end
      endcase
    end
  end

  // outputs to the analog core and pads
  assign comparator_enable_o = comparator_enable_bit;
  assign hysteresis_select_o = hyst_sel;
  assign positive_input_select_o = positive_input_select;
  assign negative_input_select_o = negative_input_select;
  assign external_input_pin_enables_o = external_input_pin_enables;
  assign reference_generator_enable_o = reference_generator_enable;
  assign reference_source_select_o = reference_source_select;
  assign reference_level_code_o = reference_level_code;
  assign result_pin_o = synced_compare_result;
  assign result_pin_oe_o = result_pin_enable;
  assign irq_o = irq_q;
  assign wake_o = u_eif.wake; // clockless by nature, the clock may be stopped

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  property p_pin_rsvd;
    rd_i && (addr_i == OFS_PIN_EN) |=> rdata_o[7:3] == 5'h00;
  endproperty
  a_pin_rsvd: assert property (p_pin_rsvd) else $error("reserved pin bits nonzero");

  property p_pin_wr;
    wr_pin ##1 !wr_pin ##1 (rd_i && addr_i == OFS_PIN_EN) |=>
      rdata_o[2:0] == $past(wdata_i[2:0], 3);
  endproperty
  a_pin_wr: assert property (p_pin_wr) else $error("pin enable readback wrong");

  property p_ref_wr;
    wr_ref |=> reference_level_code_o == $past(wdata_i[5:0]) &&
               reference_generator_enable_o == $past(wdata_i[REF_EN_BIT]) &&
               comparator_enable_o == $past(comparator_enable_o);
  endproperty
  a_ref_wr: assert property (p_ref_wr) else $error("reference write wrong");

  property p_reset;
    $fell(srst_i) |-> !comparator_enable_o && !reference_generator_enable_o && !irq_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state not default");

  property p_disabled_zero;
    !comparator_enable_bit |=> !synced_compare_result;
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("result not zero");

  property p_sync_track;
    (comparator_enable_bit && !stop_mode_i) [*3] |=>
      synced_compare_result == $past(raw_compare_output_i, 2);
  endproperty
  a_sync_track: assert property (p_sync_track) else $error("result not tracking");

  property p_stop_hold;
    stop_mode_i [*2] |-> $stable(synced_compare_result);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("result moved in stop");

  property p_flag_lag;
    (comparator_enable_bit && !stop_mode_i && edge_sensitivity_select == MODE_BOTH) [*5]
      ##0 ($past(raw_compare_output_i, 2) != $past(raw_compare_output_i, 3))
      |=> edge_event_flag;
  endproperty
  a_flag_lag: assert property (p_flag_lag) else $error("flag late or missing");

  property p_flag_sticky;
    edge_event_flag && !flag_clear |=> edge_event_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_flag_clear;
    flag_clear && !u_eif.edge_hit |=> !edge_event_flag && !irq_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_irq;
    irq_o == (edge_event_flag && edge_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_no_set_stop;
    stop_mode_i && !edge_event_flag |=> !edge_event_flag;
  endproperty
  a_no_set_stop: assert property (p_no_set_stop) else $error("flag set while stopped");

  property p_wake;
    stop_mode_i && comparator_enable_bit && edge_irq_enable &&
      edge_sensitivity_select == MODE_BOTH &&
      (raw_compare_output_i != synced_compare_result) |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in stop");

  property p_once;
    u_eif.edge_hit && !stop_mode_i |=> result_prev == $past(synced_compare_result);
  endproperty
  a_once: assert property (p_once) else $error("edge history stale");

  property p_pin_out;
    !result_pin_enable |-> !result_pin_oe_o ##0 result_pin_o == synced_compare_result;
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin driven while off");

  property p_wake_idle;
    !stop_mode_i |-> !wake_o;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("wake outside stop");

  property p_result_rd_off;
    rd_i && addr_i == OFS_STATUS_CTRL && !comparator_enable_bit |=> !rdata_o[CS_RESULT_BIT];
  endproperty
  a_result_rd_off: assert property (p_result_rd_off) else $error("result read nonzero");

  property p_edge_once;
    u_eif.edge_hit |=> !u_eif.edge_hit || $changed(synced_compare_result);
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge counted twice");

  property p_rise_only;
    u_eif.edge_hit && edge_sensitivity_select == MODE_RISE |-> synced_compare_result;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("falling edge in rise mode");

  property p_fall_only;
    u_eif.edge_hit && !edge_sensitivity_select[0] |-> !synced_compare_result;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rising edge in fall mode");
endmodule : acd_comparator_dac_control
`default_nettype wire

/* File: verification/acd_cmp_core_model.sv */
// behavioural model of the analog comparator and reference generator core
`timescale 1ns/100ps
`default_nettype none
module acd_cmp_core_model
  import acd_pkg::*;
#(
  parameter int FS_SUPPLY = 640,
  parameter int FS_BANDGAP = 320
) (
  input wire logic comparator_enable_i,
  input wire logic [acd_pkg::SEL_W-1:0] pos_sel_i,
  input wire logic [acd_pkg::SEL_W-1:0] neg_sel_i,
  input wire logic [acd_pkg::PIN_EN_W-1:0] pin_en_i,
  input wire logic ref_en_i,
  input wire logic ref_src_i,
  input wire logic [acd_pkg::REF_CODE_W-1:0] ref_code_i,
  input wire logic [9:0] ext0_level_i,
  input wire logic [9:0] ext1_level_i,
  output logic raw_compare_output_o
);
  int ref_level;
  int ext0_in;
  int ext1_in;
  int pos_level;
  int neg_level;

  // input mux: reserved code feeds ground
  function automatic int pick(input logic [1:0] sel, input int e0, input int e1, input int r);
    case (sel)
      SEL_EXT0: return e0;
      SEL_EXT1: return e1;
      SEL_REF: return r;
      default: return 0;
    endcase
  endfunction : pick

  // levels at the pads and the reference, then the comparison itself
  always_comb begin
    ref_level = ref_en_i ? (int'(ref_code_i) + 1) : 0;
    ref_level = ref_level * (ref_src_i ? FS_SUPPLY : FS_BANDGAP) / 64;
    ext0_in = pin_en_i[0] ? int'(ext0_level_i) : 0;
    ext1_in = pin_en_i[1] ? int'(ext1_level_i) : 0;
    pos_level = pick(pos_sel_i, ext0_in, ext1_in, ref_level);
    neg_level = pick(neg_sel_i, ext0_in, ext1_in, ref_level);
    raw_compare_output_o = comparator_enable_i && (pos_level > neg_level);
  end
endmodule : acd_cmp_core_model
`default_nettype wire

/* File: verification/test_acd_comparator_dac_control.sv */
// self-checking testbench of the comparator and reference control block
`timescale 1ns/100ps
`default_nettype none
module test_acd_comparator_dac_control;
  import acd_pkg::*;
  localparam logic [9:0] LOW = 10'h032;
  localparam logic [9:0] HIGH = 10'h12c;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic [9:0] ext0 = 10'h000;
  logic [9:0] ext1 = 10'h000;
  logic [7:0] rdata_o;
  logic raw, comparator_enable_o, hysteresis_select_o, reference_generator_enable_o;
  logic reference_source_select_o, result_pin_o, result_pin_oe_o, irq_o, wake_o;
  logic [1:0] positive_input_select_o, negative_input_select_o;
  logic [2:0] external_input_pin_enables_o;
  logic [5:0] reference_level_code_o;
  logic [1:0] m;
  logic f, f2;
  logic [7:0] d;
  int errors = 0;
  int checked = 0;
  int code, src, e0, e1, nsel, lvl;

  // bus clock, 5 ns period
  always #2.5 clk_sys_i = ~clk_sys_i;

  acd_comparator_dac_control acd_comparator_dac_control_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .stop_mode_i(stop_mode_i), .raw_compare_output_i(raw),
    .comparator_enable_o(comparator_enable_o), .hysteresis_select_o(hysteresis_select_o),
    .positive_input_select_o(positive_input_select_o),
    .negative_input_select_o(negative_input_select_o),
    .external_input_pin_enables_o(external_input_pin_enables_o),
    .reference_generator_enable_o(reference_generator_enable_o),
    .reference_source_select_o(reference_source_select_o),
    .reference_level_code_o(reference_level_code_o), .result_pin_o(result_pin_o),
    .result_pin_oe_o(result_pin_oe_o), .irq_o(irq_o), .wake_o(wake_o));

  acd_cmp_core_model acd_cmp_core_model_i (
    .comparator_enable_i(comparator_enable_o), .pos_sel_i(positive_input_select_o),
    .neg_sel_i(negative_input_select_o), .pin_en_i(external_input_pin_enables_o),
    .ref_en_i(reference_generator_enable_o), .ref_src_i(reference_source_select_o),
    .ref_code_i(reference_level_code_o), .ext0_level_i(ext0), .ext1_level_i(ext1),
    .raw_compare_output_o(raw));

  // expected edge acceptance per sensitivity code
  function automatic logic edge_exp(input logic [1:0] mode, input logic o, input logic n);
    if (mode == 2'h1) return !o && n;
    if (mode == 2'h3) return o != n;
    return o && !n;
  endfunction : edge_exp

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wait_clk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(exp, rdata_o);
  endtask : rd_chk

  task automatic end_of_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog against a hang
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    end_of_test;
  end

  initial begin
    void'($urandom(37));
    wait_clk(2);
    srst_i <= 1'b0;
    // reset state and unmapped read
    for (int i = 0; i < 5; i++) rd_chk(8'(i), 8'h00);
    chk(8'h00, {4'h0, comparator_enable_o, reference_generator_enable_o, irq_o, wake_o});
    $display("test reset done");
    // register access and reserved bits
    wr_reg(OFS_PIN_EN, 8'hff);
    rd_chk(OFS_PIN_EN, 8'h07);
    chk(8'h07, {5'h0, external_input_pin_enables_o});
    wr_reg(OFS_INPUT_SEL, 8'hff);
    rd_chk(OFS_INPUT_SEL, 8'h33);
    chk(8'hff, {2'h3, positive_input_select_o, 2'h3, negative_input_select_o});
    d = 8'($urandom_range(0, 255));
    wr_reg(OFS_REF_CTRL, d);
    wr_reg(8'h04, 8'hff);
    rd_chk(OFS_REF_CTRL, d);
    chk(d, {reference_generator_enable_o, reference_source_select_o,
            reference_level_code_o});
    chk(8'h00, {7'h0, comparator_enable_o});
    $display("test registers done");
    // edge modes, flag hold, clear and interrupt
    wr_reg(OFS_PIN_EN, 8'h01);
    wr_reg(OFS_INPUT_SEL, 8'h03);
    wr_reg(OFS_REF_CTRL, 8'h9f);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      ext0 <= LOW;
      wr_reg(OFS_STATUS_CTRL, 8'h94 | {6'h0, m});
      wait_clk(4);
      wr_reg(OFS_STATUS_CTRL, 8'h94 | {6'h0, m});
      @(posedge clk_sys_i);
      ext0 <= HIGH;
      wait_clk(2);
      #1 chk(8'h00, {7'h0, irq_o});
      @(posedge clk_sys_i);
      f = edge_exp(m, 1'b0, 1'b1);
      #1 chk({7'h0, f}, {7'h0, irq_o});
      rd_chk(OFS_STATUS_CTRL, 8'h9c | {6'h0, m} | {2'h0, f, 5'h0});
      chk(8'h03, {6'h0, result_pin_o, result_pin_oe_o});
      wr_reg(OFS_STATUS_CTRL, 8'hb4 | {6'h0, m});
      rd_chk(OFS_STATUS_CTRL, 8'h9c | {6'h0, m} | {2'h0, f, 5'h0});
      @(posedge clk_sys_i);
      ext0 <= LOW;
      wait_clk(4);
      f2 = f | edge_exp(m, 1'b1, 1'b0);
      rd_chk(OFS_STATUS_CTRL, 8'h94 | {6'h0, m} | {2'h0, f2, 5'h0});
      wr_reg(OFS_STATUS_CTRL, 8'h94 | {6'h0, m});
      wait_clk(4);
      #1 chk(8'h00, {7'h0, irq_o});
    end
    $display("test edges done");
    // disabled comparator forces the result low
    ext0 <= HIGH;
    wr_reg(OFS_STATUS_CTRL, 8'h44);
    wait_clk(4);
    rd_chk(OFS_STATUS_CTRL, 8'h44);
    chk(8'h0b, {4'h0, hysteresis_select_o, result_pin_o, result_pin_oe_o,
                reference_generator_enable_o});
    $display("test disabled done");
    // stop mode: wake request, frozen result, resync afterwards
    ext0 <= LOW;
    wr_reg(OFS_STATUS_CTRL, 8'h93);
    wait_clk(4);
    wr_reg(OFS_STATUS_CTRL, 8'h93);
    stop_mode_i <= 1'b1;
    wait_clk(2);
    ext0 <= HIGH;
    wait_clk(1);
    #1 chk(8'h01, {7'h0, wake_o});
    wait_clk(4);
    #1 chk(8'h00, {7'h0, irq_o});
    rd_chk(OFS_STATUS_CTRL, 8'h93);
    @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    wait_clk(4);
    #1 chk(8'h02, {6'h0, irq_o, wake_o});
    rd_chk(OFS_STATUS_CTRL, 8'hbb);
    $display("test stop done");
    // random reference codes, sources and levels
    for (int i = 0; i < 40; i++) begin
      code = $urandom_range(0, 63);
      src = $urandom_range(0, 1);
      nsel = $urandom_range(0, 1);
      e0 = $urandom_range(0, 640);
      e1 = $urandom_range(0, 640);
      wr_reg(OFS_STATUS_CTRL, 8'h00);
      wr_reg(OFS_PIN_EN, 8'h03);
      wr_reg(OFS_INPUT_SEL, {2'h0, SEL_EXT0, 2'h0, nsel ? SEL_EXT1 : SEL_REF});
      wr_reg(OFS_REF_CTRL, {1'b0, 1'(src), 6'(code)});
      wr_reg(OFS_REF_CTRL, {1'b1, 1'(src), 6'(code)});
      ext0 <= 10'(e0);
      ext1 <= 10'(e1);
      wr_reg(OFS_STATUS_CTRL, 8'h80);
      wait_clk(4);
      lvl = nsel ? e1 : (code + 1) * (src ? 640 : 320) / 64;
      rd_chk(OFS_STATUS_CTRL, (e0 > lvl) ? 8'h88 : 8'h80);
      chk(8'(code), {2'h0, reference_level_code_o});
    end
    $display("test random done");
    end_of_test;
  end
endmodule : test_acd_comparator_dac_control
`default_nettype wire
